// file: hw/encoder_diag_attribute_bank.v
// Purpose: warnings, time counters, temperature supervision, special function
//          control and peak records of an absolute encoder attribute map
// Assumes: attribute get/set arrive as one-cycle strobes synchronous to clk
// Notes: answers come one cycle after the strobe; counters restart at reset
//        limits are not rescaled when the temperature unit changes
//        time counters and peak records start from zero; no restore path here
//
// Overview of operation
// (RQ1) operating time counts in steps of a tenth hour, 32-bit unsigned
// (RQ2) temperature unit accepts 1200h Celsius, 1201h Fahrenheit, defaults Celsius
// (RQ3) temperature step size in hundredths of a degree, default 100
// (RQ4) reading outside low or high limit sets the temperature warning flag
// (RQ5) signed 16-bit limits default F060h low and 2710h high
// (RQ6) control bit 0 turns peer sign-of-life supervision on or off
// (RQ7) control bits 8..15 hold update factor, valid 2 to 127
// (RQ8) control bit 16 selects storage mode, 0 automatic, 1 manual
// (RQ9) operating seconds counter advances once per second of operation
// (RQ10) peak speed record updates only when current speed exceeds it
// (RQ11) warning indicator is one when any supported warning bit is set
`include "encoder_diag_consts.vh"
`default_nettype none

module encoder_diag_attribute_bank #(
    parameter integer CLKS_PER_SECOND = (`CLK_FREQ_HZ * `SECOND_TIME_S),
    parameter integer SECONDS_PER_TENTH_HOUR = `TENTH_HOUR_TIME_S
) (
    input wire clk,
    input wire rst_n,
    input wire attr_get,
    input wire attr_set,
    input wire [7:0] attr_id,
    input wire [31:0] attr_wdata,
    input wire [15:0] temp_value,
    input wire [31:0] speed_value,
    input wire [31:0] accel_value,
    input wire moving,
    input wire [15:0] ext_warnings,
    input wire [31:0] preset_offset_in,
    input wire [31:0] fault_summary_in,
    output reg [31:0] attr_rdata_q,
    output reg attr_ack_q,
    output reg attr_err_q,
    output reg [31:0] special_function_ctrl_q,
    output reg [15:0] temp_unit_select_q,
    output reg [31:0] temp_step_size_q
);

    localparam integer WARN_WIDTH = 16;

    reg [15:0] warning_bits_q;
    reg warning_indicator_q;
    reg [31:0] run_hours_tenths_q;
    reg [31:0] run_seconds_q;
    reg [31:0] motion_seconds_q;
    reg [31:0] peak_speed_q;
    reg [31:0] peak_accel_q;
    reg [15:0] temp_low_limit_q;
    reg [15:0] temp_high_limit_q;
    reg [31:0] tick_cnt_q;
    reg [31:0] tenth_cnt_q;
    reg second_tick_q;

    reg [15:0] warning_bits_d;
    reg temp_out_of_range;
    reg [31:0] rdata_d;
    reg err_d;
    reg [7:0] new_factor;
    reg [31:0] ctrl_wr_value;
    wire [WARN_WIDTH-1:0] warning_mask = `SUPPORTED_WARNING_MASK_VAL;
    wire [WARN_WIDTH-1:0] warning_src;
    genvar wb;

    // one-cycle second enable from the system clock
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_cnt_q <= 32'h00000000;
            second_tick_q <= 1'b0;
        end
        else if (tick_cnt_q == CLKS_PER_SECOND - 1)
        begin
            tick_cnt_q <= 32'h00000000;
            second_tick_q <= 1'b1;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_q + 32'h00000001;
            second_tick_q <= 1'b0;
        end
    end

    // time counters; a restore from non-volatile storage is outside this block
    // operating seconds advance on every tick while powered
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run_seconds_q <= 32'h00000000;
        end
        else if (second_tick_q)
        begin
            run_seconds_q <= run_seconds_q + 32'h00000001; // [RQ9]
        end
    end

    // motion seconds only count ticks that find the shaft moving
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            motion_seconds_q <= 32'h00000000;
        end
        else if (second_tick_q && moving)
        begin
            motion_seconds_q <= motion_seconds_q + 32'h00000001;
        end
    end

    // tenth-hour steps are built from whole seconds, so they share the seconds phase
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run_hours_tenths_q <= 32'h00000000;
            tenth_cnt_q <= 32'h00000000;
        end
        else if (second_tick_q)
        begin
            if (tenth_cnt_q == SECONDS_PER_TENTH_HOUR - 1)
            begin
                tenth_cnt_q <= 32'h00000000;
                run_hours_tenths_q <= run_hours_tenths_q + 32'h00000001; // [RQ1]
            end
            else
            begin
                tenth_cnt_q <= tenth_cnt_q + 32'h00000001;
            end
        end
    end

    // peak records never fall back, so a slow drop in speed leaves them alone
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            peak_speed_q <= 32'h00000000;
        end
        else if (speed_value > peak_speed_q)
        begin
            peak_speed_q <= speed_value; // [RQ10]
        end
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            peak_accel_q <= 32'h00000000;
        end
        else if (accel_value > peak_accel_q)
        begin
            peak_accel_q <= accel_value;
        end
    end

    // warnings follow their sources live; only supported bits can show
    always @*
    begin
        temp_out_of_range = ($signed(temp_value) < $signed(temp_low_limit_q)) ||
                            ($signed(temp_value) > $signed(temp_high_limit_q)); // [RQ4]
        warning_bits_d = warning_src;
    end

    // one cell per warning bit; the temperature flag takes the place of its external source
    generate
        for (wb = 0; wb < WARN_WIDTH; wb = wb + 1)
        begin : g_warn
            if (wb == `WARN_TEMP_BIT)
            begin : g_temp
                assign warning_src[wb] = temp_out_of_range & warning_mask[wb]; // [RQ4]
            end
            else
            begin : g_ext
                assign warning_src[wb] = ext_warnings[wb] & warning_mask[wb];
            end
        end
    endgenerate

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            warning_bits_q <= 16'h0000;
            warning_indicator_q <= 1'b0;
        end
        else
        begin
            warning_bits_q <= warning_bits_d;
            warning_indicator_q <= |warning_bits_d; // [RQ11]
        end
    end

    // read mux and set validation
    always @*
    begin
        rdata_d = 32'h00000000;
        err_d = 1'b0;
        new_factor = attr_wdata[`SFC_UPDATE_FACTOR_MSB:`SFC_UPDATE_FACTOR_LSB];
        case (attr_id)
            `ATTR_WARNING_BITS: rdata_d = {16'h0000, warning_bits_q};
            `ATTR_SUPPORTED_WARNING_MASK: rdata_d = {16'h0000, `SUPPORTED_WARNING_MASK_VAL};
            `ATTR_WARNING_INDICATOR: rdata_d = {31'h00000000, warning_indicator_q};
            `ATTR_RUN_HOURS_TENTHS: rdata_d = run_hours_tenths_q;
            `ATTR_PRESET_OFFSET: rdata_d = preset_offset_in;
            `ATTR_TEMP_READING: rdata_d = {16'h0000, temp_value};
            `ATTR_TEMP_UNIT_SELECT: rdata_d = {16'h0000, temp_unit_select_q};
            `ATTR_TEMP_STEP_SIZE: rdata_d = temp_step_size_q;
            `ATTR_TEMP_LOW_LIMIT: rdata_d = {16'h0000, temp_low_limit_q};
            `ATTR_TEMP_HIGH_LIMIT: rdata_d = {16'h0000, temp_high_limit_q};
            `ATTR_FAULT_SUMMARY_WORD: rdata_d = fault_summary_in;
            `ATTR_SPECIAL_FUNCTION_CTRL: rdata_d = special_function_ctrl_q;
            `ATTR_MOTION_SECONDS: rdata_d = motion_seconds_q;
            `ATTR_RUN_SECONDS: rdata_d = run_seconds_q;
            `ATTR_PEAK_SPEED: rdata_d = peak_speed_q;
            `ATTR_PEAK_ACCEL: rdata_d = peak_accel_q;
            default: err_d = 1'b1;
        endcase
        if (attr_set)
        begin
            case (attr_id)
                `ATTR_TEMP_UNIT_SELECT:
                begin
                    err_d = (attr_wdata[15:0] != `TEMP_UNIT_CELSIUS) &&
                            (attr_wdata[15:0] != `TEMP_UNIT_FAHRENHEIT); // [RQ2]
                end
                `ATTR_TEMP_STEP_SIZE: err_d = 1'b0;
                `ATTR_TEMP_LOW_LIMIT: err_d = 1'b0;
                `ATTR_TEMP_HIGH_LIMIT: err_d = 1'b0;
                `ATTR_SPECIAL_FUNCTION_CTRL:
                begin
                    err_d = (new_factor < `UPDATE_FACTOR_MIN) ||
                            (new_factor > `UPDATE_FACTOR_MAX); // [RQ7]
                end
                default: err_d = 1'b1;
            endcase
        end
    end

    // the stored control word is assembled field by field; unused bits always read zero
    always @*
    begin
        ctrl_wr_value = 32'h00000000;
        ctrl_wr_value[`SFC_SIGN_OF_LIFE_BIT] = attr_wdata[`SFC_SIGN_OF_LIFE_BIT]; // [RQ6]
        ctrl_wr_value[`SFC_UPDATE_FACTOR_MSB:`SFC_UPDATE_FACTOR_LSB] = new_factor; // [RQ7]
        ctrl_wr_value[`SFC_STORAGE_MODE_BIT] = attr_wdata[`SFC_STORAGE_MODE_BIT]; // [RQ8]
        ctrl_wr_value[`SFC_FW_UPDATE_MSB:`SFC_FW_UPDATE_LSB] =
            attr_wdata[`SFC_FW_UPDATE_MSB:`SFC_FW_UPDATE_LSB];
    end

    // writable settings; a refused set leaves the old value in place
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            temp_unit_select_q <= `TEMP_UNIT_CELSIUS; // [RQ2]
            temp_step_size_q <= `TEMP_STEP_SIZE_RST; // [RQ3]
            temp_low_limit_q <= `TEMP_LOW_LIMIT_RST; // [RQ5]
            temp_high_limit_q <= `TEMP_HIGH_LIMIT_RST; // [RQ5]
            special_function_ctrl_q <= `SPECIAL_FUNCTION_CTRL_RST;
        end
        else if (attr_set && !err_d)
        begin
            case (attr_id)
                `ATTR_TEMP_UNIT_SELECT: temp_unit_select_q <= attr_wdata[15:0]; // [RQ2]
                `ATTR_TEMP_STEP_SIZE: temp_step_size_q <= attr_wdata; // [RQ3]
                `ATTR_TEMP_LOW_LIMIT: temp_low_limit_q <= attr_wdata[15:0]; // [RQ5]
                `ATTR_TEMP_HIGH_LIMIT: temp_high_limit_q <= attr_wdata[15:0]; // [RQ5]
                `ATTR_SPECIAL_FUNCTION_CTRL:
                    special_function_ctrl_q <= ctrl_wr_value; // [RQ6] [RQ8]
                default: special_function_ctrl_q <= special_function_ctrl_q;
            endcase
        end
    end

    // answer one cycle after each strobe; read data holds until the next answer
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            attr_rdata_q <= 32'h00000000;
            attr_ack_q <= 1'b0;
            attr_err_q <= 1'b0;
        end
        else
        begin
            attr_ack_q <= attr_get || attr_set;
            if (attr_get || attr_set)
            begin
                attr_err_q <= err_d;
                attr_rdata_q <= (attr_get && !err_d) ? rdata_d : 32'h00000000;
            end
        end
    end

endmodule

`default_nettype wire

// file: inc/encoder_diag_consts.vh
// Purpose: constants for the encoder diagnostic attribute bank
// Assumes: attribute ids are the printed attribute numbers
// Notes: widths and counts that may differ are module parameters
`ifndef ENCODER_DIAG_CONSTS_VH
`define ENCODER_DIAG_CONSTS_VH

// attribute ids
`define ATTR_WARNING_BITS 8'h2F
`define ATTR_SUPPORTED_WARNING_MASK 8'h30
`define ATTR_WARNING_INDICATOR 8'h31
`define ATTR_RUN_HOURS_TENTHS 8'h32
`define ATTR_PRESET_OFFSET 8'h33
`define ATTR_TEMP_READING 8'h64
`define ATTR_TEMP_UNIT_SELECT 8'h65
`define ATTR_TEMP_STEP_SIZE 8'h66
`define ATTR_TEMP_LOW_LIMIT 8'h67
`define ATTR_TEMP_HIGH_LIMIT 8'h68
`define ATTR_FAULT_SUMMARY_WORD 8'h69
`define ATTR_SPECIAL_FUNCTION_CTRL 8'h6A
`define ATTR_MOTION_SECONDS 8'h6B
`define ATTR_RUN_SECONDS 8'h6C
`define ATTR_PEAK_SPEED 8'h6D
`define ATTR_PEAK_ACCEL 8'h6E

// reset values, the supported warning mask and the temperature unit codes
`define SUPPORTED_WARNING_MASK_VAL 16'h67C3
`define TEMP_UNIT_CELSIUS 16'h1200
`define TEMP_UNIT_FAHRENHEIT 16'h1201
`define TEMP_STEP_SIZE_RST 32'h00000064
`define TEMP_LOW_LIMIT_RST 16'hF060
`define TEMP_HIGH_LIMIT_RST 16'h2710
`define SPECIAL_FUNCTION_CTRL_RST 32'h01000500

// special function control fields
`define SFC_SIGN_OF_LIFE_BIT 0
`define SFC_UPDATE_FACTOR_LSB 8
`define SFC_UPDATE_FACTOR_MSB 15
`define SFC_STORAGE_MODE_BIT 16
`define SFC_FW_UPDATE_LSB 24
`define SFC_FW_UPDATE_MSB 31
`define SFC_WRITABLE_MASK 32'hFF01FF01
`define UPDATE_FACTOR_MIN 8'h02
`define UPDATE_FACTOR_MAX 8'h7F

// temperature supervision flag position in warning_bits
`define WARN_TEMP_BIT 13

// timing
`define CLK_FREQ_HZ 100000000
`define SECOND_TIME_S 1
`define TENTH_HOUR_TIME_S 360

`endif

// file: verification/encoder_diag_sva.sv
// Purpose: assertions on the attribute port of the diagnostic bank
// Assumes: one strobe per cycle, answer one cycle later
// Notes: refused sets must leave the stored word untouched
`include "encoder_diag_consts.vh"
`default_nettype none
module encoder_diag_sva #(
    parameter integer CLKS_PER_SECOND = 10,
    parameter integer SECONDS_PER_TENTH_HOUR = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic attr_get,
    input wire logic attr_set,
    input wire logic [7:0] attr_id,
    input wire logic [31:0] attr_wdata,
    input wire logic attr_ack_q,
    input wire logic attr_err_q,
    input wire logic [31:0] special_function_ctrl_q,
    input wire logic [15:0] temp_unit_select_q,
    input wire logic [31:0] temp_step_size_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic uw = attr_set && attr_id == `ATTR_TEMP_UNIT_SELECT;
    wire logic ul = attr_wdata[15:0] == 16'h1200 || attr_wdata[15:0] == 16'h1201;
    wire logic cw = attr_set && attr_id == `ATTR_SPECIAL_FUNCTION_CTRL;
    wire logic fv = attr_wdata[15:8] >= 8'h02 && attr_wdata[15:8] <= 8'h7F;
    a_unit_legal: assert property (temp_unit_select_q inside {16'h1200, 16'h1201})
        else $error("unit select holds an illegal code");
    a_unit_write: assert property (uw && ul
        |=> temp_unit_select_q == $past(attr_wdata[15:0]))
        else $error("legal unit code not taken");
    a_unit_refuse: assert property (uw && !ul
        |=> attr_err_q && $stable(temp_unit_select_q))
        else $error("illegal unit code not refused");
    a_step_write: assert property (attr_set && attr_id == `ATTR_TEMP_STEP_SIZE
        |=> !attr_err_q && temp_step_size_q == $past(attr_wdata)) else $error("step not stored");
    a_factor_range: assert property (special_function_ctrl_q[15:8] inside {[8'h02:8'h7F]})
        else $error("update factor out of range");
    a_ctrl_write: assert property (cw && fv
        |=> special_function_ctrl_q == ($past(attr_wdata) & `SFC_WRITABLE_MASK))
        else $error("control word not stored");
    a_ctrl_refuse: assert property (cw && !fv
        |=> attr_err_q && $stable(special_function_ctrl_q))
        else $error("bad update factor not refused");
    a_limit_write: assert property (attr_set && attr_id == `ATTR_TEMP_LOW_LIMIT
        |=> attr_ack_q && !attr_err_q) else $error("limit write refused");
    c_ctrl: cover property (cw && fv);
    c_bad_unit: cover property (uw && !ul);
    c_get: cover property (attr_get && attr_id == `ATTR_RUN_SECONDS);
endmodule
bind encoder_diag_attribute_bank encoder_diag_sva #(.CLKS_PER_SECOND(CLKS_PER_SECOND),
    .SECONDS_PER_TENTH_HOUR(SECONDS_PER_TENTH_HOUR)) u_sva (.clk(clk), .rst_n(rst_n),
    .attr_get(attr_get), .attr_set(attr_set), .attr_id(attr_id), .attr_wdata(attr_wdata),
    .attr_ack_q(attr_ack_q), .attr_err_q(attr_err_q), .temp_step_size_q(temp_step_size_q),
    .special_function_ctrl_q(special_function_ctrl_q), .temp_unit_select_q(temp_unit_select_q));
`default_nettype wire

// file: verification/attr_controller_model.sv
// Purpose: network controller issuing attribute get and set
// Assumes: answer lands on the edge after the taking edge
// Notes: idle id and data lines are inverted so stale values never look valid
`default_nettype none
module attr_controller_model (
    input wire logic clk,
    input wire logic [31:0] attr_rdata_q,
    input wire logic attr_ack_q,
    input wire logic attr_err_q,
    output var logic attr_get,
    output var logic attr_set,
    output var logic [7:0] attr_id,
    output var logic [31:0] attr_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {attr_get, attr_set, attr_id, attr_wdata} = '0;
    task automatic xfer(input logic s, input logic [7:0] id, input logic [31:0] wd,
        output logic [31:0] rd, output logic [1:0] ae);
        @(posedge clk);
        attr_get <= !s;
        attr_set <= s;
        attr_id <= id;
        attr_wdata <= wd;
        @(posedge clk);
        attr_get <= 1'b0;
        attr_set <= 1'b0;
        attr_id <= ~id;
        attr_wdata <= ~wd;
        @(posedge clk);
        rd = attr_rdata_q;
        ae = {attr_ack_q, attr_err_q};
    endtask
endmodule
`default_nettype wire

// file: verification/encoder_diag_attribute_bank_tb_top.sv
// Purpose: self-checking bench for the diagnostic attribute bank
// Assumes: a second is 10 cycles and a tenth hour 3 seconds here
// Notes: register rows first, then supervision, peaks, counters, reset
`default_nettype none
module encoder_diag_attribute_bank_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic s; logic [7:0] id; logic [31:0] wd;
        logic er; logic [31:0] rd;} row_t;
    row_t rows [22] = '{{1'b0,8'h30,32'h0,1'b0,32'h67C3}, {1'b0,8'h65,32'h0,1'b0,32'h1200},
        {1'b0,8'h66,32'h0,1'b0,32'h64}, {1'b0,8'h67,32'h0,1'b0,32'hF060},
        {1'b0,8'h68,32'h0,1'b0,32'h2710}, {1'b0,8'h6A,32'h0,1'b0,32'h01000500},
        {1'b0,8'h31,32'h0,1'b0,32'h0}, {1'b0,8'h33,32'h0,1'b0,32'h12345678},
        {1'b0,8'h50,32'h0,1'b1,32'h0}, {1'b1,8'h2F,32'h1,1'b1,32'h0},
        {1'b1,8'h65,32'h1202,1'b1,32'h0}, {1'b1,8'h65,32'h1201,1'b0,32'h0},
        {1'b0,8'h65,32'h0,1'b0,32'h1201}, {1'b1,8'h6A,32'h8000,1'b1,32'h0},
        {1'b1,8'h6A,32'hFFFF7F81,1'b0,32'h0}, {1'b0,8'h6A,32'h0,1'b0,32'hFF017F01},
        {1'b1,8'h6A,32'h100,1'b1,32'h0}, {1'b1,8'h6A,32'h10200,1'b0,32'h0},
        {1'b0,8'h6A,32'h0,1'b0,32'h10200}, {1'b1,8'h66,32'hC8,1'b0,32'h0},
        {1'b1,8'h67,32'hFC18,1'b0,32'h0}, {1'b0,8'h69,32'h0,1'b0,32'hA5A50F0F}};
    logic [15:0] tl [4] = '{16'hFC17, 16'hFC18, 16'h2710, 16'h2711};
    logic tw [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    logic [7:0] ci [4] = '{8'h6C, 8'h6B, 8'h6B, 8'h32};
    logic [31:0] ce [4] = '{32'd9, 32'd9, 32'd0, 32'd3};
    logic [31:0] sp [3] = '{32'd100, 32'd50, 32'd200};
    logic [31:0] ep [3] = '{32'd100, 32'd100, 32'd200};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic attr_get, attr_set, attr_ack_q, attr_err_q, moving;
    logic [7:0] attr_id;
    logic [15:0] temp_value, ext_warnings, unit;
    logic [31:0] attr_wdata, attr_rdata_q, speed_value, accel_value, ctrl, step, r, a;
    logic [1:0] ae;
    int fails = 0;
    int cmp_count = 0;
    always #5 clk = ~clk;
    encoder_diag_attribute_bank #(.CLKS_PER_SECOND(10), .SECONDS_PER_TENTH_HOUR(3)) u_dut (
        .clk(clk), .rst_n(rst_n), .attr_get(attr_get), .attr_set(attr_set), .attr_id(attr_id),
        .attr_wdata(attr_wdata), .temp_value(temp_value), .speed_value(speed_value),
        .accel_value(accel_value), .moving(moving), .ext_warnings(ext_warnings),
        .preset_offset_in(32'h12345678), .fault_summary_in(32'hA5A50F0F),
        .attr_rdata_q(attr_rdata_q), .attr_ack_q(attr_ack_q), .attr_err_q(attr_err_q),
        .special_function_ctrl_q(ctrl), .temp_unit_select_q(unit), .temp_step_size_q(step));
    attr_controller_model u_ctl (.clk(clk), .attr_rdata_q(attr_rdata_q), .attr_ack_q(attr_ack_q),
        .attr_err_q(attr_err_q), .attr_get(attr_get), .attr_set(attr_set), .attr_id(attr_id),
        .attr_wdata(attr_wdata));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic g(input logic [7:0] id, output logic [31:0] v);
        u_ctl.xfer(1'b0, id, 32'h0, v, ae);
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        {temp_value, ext_warnings, speed_value, moving} = '0;
        accel_value = 32'd7;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i])
        begin
            u_ctl.xfer(rows[i].s, rows[i].id, rows[i].wd, r, ae);
            check({30'h0, ae}, {30'h0, 1'b1, rows[i].er});
            check(r, rows[i].rd);
        end
        foreach (tl[i])
        begin
            @(posedge clk) temp_value <= tl[i];
            g(8'h64, r);
            check(r, {16'h0, tl[i]});
            g(8'h2F, r);
            check(r, {18'h0, tw[i], 13'h0});
            g(8'h31, r);
            check(r, {31'h0, tw[i]});
        end
        @(posedge clk) {temp_value, ext_warnings} <= {16'h0, 16'hFFFF};
        g(8'h2F, r);
        check(r, 32'h47C3);
        g(8'h31, r);
        check(r, 32'h1);
        @(posedge clk) ext_warnings <= 16'h983C;
        g(8'h31, r);
        check(r, 32'h0);
        foreach (sp[i])
        begin
            @(posedge clk) speed_value <= sp[i];
            g(8'h6D, r);
            check(r, ep[i]);
        end
        g(8'h6E, r);
        check(r, 32'd7);
        foreach (ci[i])
        begin
            @(posedge clk) moving <= (i != 2);
            g(ci[i], a);
            repeat (87) @(posedge clk);
            g(ci[i], r);
            check(r - a, ce[i]);
        end
        u_ctl.xfer(1'b1, 8'h65, 32'h1201, r, ae);
        g(8'h6A, r);
        check(r, 32'h10200);
        @(posedge clk) rst_n <= 1'b0;
        @(posedge clk) #1;
        check({unit, 16'h0}, 32'h12000000);
        check(ctrl, 32'h01000500);
        check(step, 32'h64);
        check(attr_rdata_q, 32'h0);
        check({30'h0, attr_ack_q, attr_err_q}, 32'h0);
        @(posedge clk) rst_n <= 1'b1;
        g(8'h67, r);
        check(r, 32'hF060);
        g(8'h6C, r);
        check(r, 32'h0);
        summarize;
    end
    initial
    begin
        #50us;
        fails++;
        summarize;
    end
endmodule
`default_nettype wire
